// *** afb_pkg.sv ***
package afb_pkg;
  // port width
  localparam int unsigned DATA_W      = 8;
  // buffer depth
  localparam int unsigned FIFO_DEPTH  = 32;
  // interface clock of the synchronous mode
  localparam int unsigned SYNC_CLK_MHZ = 60;
  // system clock rate and period
  localparam int unsigned SYS_CLK_HZ  = 20000000;
  localparam int unsigned SYS_CLK_NS  = 50;
  // bit-bang strobe width, in ns, and the count derived from it
  localparam int unsigned STB_NS      = 100;
  localparam int unsigned STB_CYC     = (STB_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam logic [3:0]  STB_CYC_W   = 4'(STB_CYC);
  // mode select codes from the configuration memory
  localparam logic [1:0]  MODE_OFF    = 2'h0;
  localparam logic [1:0]  MODE_AFIFO  = 2'h1;
  localparam logic [1:0]  MODE_BB     = 2'h2;
  // reset values
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [3:0]  CNT_RST     = 4'h0;

  // port states, one-hot
  typedef enum logic [3:0] {
    AFB_IDLE  = 4'b0001,  // no mode or waiting
    AFB_RD    = 4'b0010,  // read strobe low, bus driven
    AFB_WR    = 4'b0100,  // write strobe low, waiting for rise
    AFB_BB    = 4'b1000   // bit-bang mode
  } afb_state_e;
endpackage

// *** afb_stream_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// byte stream between producer and consumer
interface afb_stream_if #(parameter int unsigned W = 8);
  logic [W-1:0] data;   // payload
  logic         valid;  // producer has a byte
  logic         ready;  // consumer takes it
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// *** afb_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
// synchronous fifo with valid/ready on both sides
module afb_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic   i_sys_clk,
  input  wire logic   i_nrst,
  afb_stream_if.snk   wr,
  afb_stream_if.src   rd
);
  localparam int unsigned AW = $clog2(DEPTH);

  // depth check
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("afb_fifo: depth must be a power of two");
  end

  // storage
  logic [WIDTH-1:0] mem [DEPTH];

  typedef struct packed {
    logic [AW:0] wp;  // write pointer
    logic [AW:0] rp;  // read pointer
  } afb_fifo_s;

  afb_fifo_s s_q, s_d;
  logic full, empty;

  // flags from pointers
  assign empty    = (s_q.wp == s_q.rp);
  assign full     = (s_q.wp[AW] != s_q.rp[AW]) && (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data  = mem[s_q.rp[AW-1:0]];

  // pointer update
  always_comb
  begin
    s_d = s_q;
    if (wr.valid && !full)
      s_d.wp = s_q.wp + 1'b1;
    if (rd.ready && !empty)
      s_d.rp = s_q.rp + 1'b1;
  end

  // state register
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // storage write, no reset
  always_ff @(posedge i_sys_clk)
  begin
    if (wr.valid && !full)
      mem[s_q.wp[AW-1:0]] <= wr.data;
  end
endmodule
`default_nettype wire

// *** afb_strobe_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
// one high pulse of fixed width on request
module afb_strobe_gen #(
  parameter logic [3:0] WIDTH = 4'h2
) (
  input  wire logic i_sys_clk,
  input  wire logic i_nrst,
  input  wire logic i_fire,    // start pulse
  output logic      o_pulse    // high while the strobe is active
);
  initial
  begin
    if (WIDTH == 4'h0)
      $error("afb_strobe_gen: width must be nonzero");
  end

  typedef struct packed {
    logic [3:0] cnt;  // cycles left
    logic       act;  // strobe active
  } afb_stb_s;

  afb_stb_s s_q, s_d;

  // countdown
  always_comb
  begin
    s_d = s_q;
    if (i_fire)
    begin
      s_d.cnt = WIDTH;
      s_d.act = 1'b1;
    end
    else if (s_q.act)
    begin
      s_d.cnt = s_q.cnt - 4'h1;
      if (s_q.cnt == 4'h1)
        s_d.act = 1'b0;
    end
  end

  // state register
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign o_pulse = s_q.act;
endmodule
`default_nettype wire

// *** afb_port.sv ***
// Function
// - in fifo mode, data lines driven only while read strobe low
// - receive-available low while a byte waits
// - read strobe rise forces receive-available high
// - status outputs released during reset
// - transmit-space low when a byte fits
// - read strobe fall presents the buffer byte
// - read strobe rise advances the receive buffer
// - write strobe fall captures the data lines
// - fifo mode only when configuration selects it
// - wakeup pulse in suspend requests resume
// - wakeup pulse when active flushes receive data
// - bit-bang makes lines a bidirectional bus
// - bit-bang host write gives write flag low
// - bit-bang sample gives sample flag rising edge
`timescale 1ns/1ps
`default_nettype none
module afb_port
  import afb_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_nrst,
  input  wire logic [1:0]        i_cfg_mode,        // mode from configuration memory
  input  wire logic              i_bb_cmd,          // host command selects bit-bang
  input  wire logic              i_remote_wake_en,  // remote wakeup configured
  input  wire logic              i_power_enable_n,  // 1 = bus suspended
  input  wire logic [7:0]        i_port_data_lines, // pin level
  output logic      [7:0]        o_port_data_lines, // pin drive value
  output logic      [7:0]        o_port_data_oe,    // pin drive enable
  input  wire logic              i_rd_n,            // external read strobe
  input  wire logic              i_wr_n,            // external write strobe
  input  wire logic              i_send_now_wakeup_n,
  output logic                   o_rx_available_n,
  output logic                   o_rx_available_oe,
  output logic                   o_tx_space_n,
  output logic                   o_tx_space_oe,
  output logic                   o_pin_write_flag_n,
  output logic                   o_pin_sample_flag_n,
  // usb engine side, receive stream in
  input  wire logic [7:0]        i_rx_data,
  input  wire logic              i_rx_valid,
  output logic                   o_rx_ready,
  // usb engine side, transmit stream out
  output logic      [7:0]        o_tx_data,
  output logic                   o_tx_valid,
  input  wire logic              i_tx_ready,
  // bit-bang host side
  input  wire logic [7:0]        i_bb_out_data,     // host value for the pins
  input  wire logic [7:0]        i_bb_out_dir,      // 1 = pin driven
  input  wire logic              i_bb_out_wr,       // host wrote new value
  input  wire logic              i_bb_sample,       // host asks for a sample
  output logic      [7:0]        o_bb_in_data,      // sampled value
  output logic                   o_bb_in_valid,     // sample forwarded
  // engine requests
  output logic                   o_resume_req,      // one-cycle pulse
  output logic                   o_flush_req        // one-cycle pulse
);
  // the port between pins and engine
  // async fifo mode: strobe handshakes
  // bit-bang mode: pins as a plain bus
  // wakeup input shared by all modes
  // engine sides are valid/ready streams
  // parameter check
  initial
  begin
    if (DEPTH < 2)
      $error("afb_port: depth too small");
  end

  // read handshake, as the far side sees it
  // strobe fall sampled on a clock edge
  // bus driven from that same edge
  // byte stays put while the strobe is low
  // strobe rise: bus released, flag high
  // buffer pops on that same edge
  // flag may fall again one cycle later
  // so a fast host sees the flag bounce
  // a fall while the flag is high is lost
  // strobe levels need one clock each
  // shorter pulses may slip between edges
  // bus drive can overlap a host write
  // all state of the port
  typedef struct packed {
    afb_state_e        st;        // port state
    logic              rd_n;      // previous read strobe
    logic              wr_n;      // previous write strobe
    logic              wk_n;      // previous wakeup level
    logic              rxa_n;     // receive-available
    logic              rxa_oe;    // its enable
    logic              txs_n;     // transmit-space
    logic              txs_oe;    // its enable
    logic [7:0]        dout;      // bus drive value
    logic [7:0]        doe;       // bus drive enable
    logic              wflag_n;   // bit-bang write flag
    logic              sflag_n;   // bit-bang sample flag
    logic [7:0]        bb_in;     // sampled value
    logic              bb_v;      // sample valid
    logic              resume;    // resume pulse
    logic              flush;     // flush pulse
  } afb_port_s;

  afb_port_s s_q, s_d;

  // two buffers of equal depth
  // receive side: engine fills, pins drain
  // transmit side: pins fill, engine drains
  // engine receive stream is gated by the mode
  // so no new byte enters while the port is off
  // full buffer holds off the engine
  // empty buffer keeps the flag high
  // buffer streams
  afb_stream_if #(.W(DATA_W)) rx_in  ();
  afb_stream_if #(.W(DATA_W)) rx_out ();
  afb_stream_if #(.W(DATA_W)) tx_in  ();
  afb_stream_if #(.W(DATA_W)) tx_out ();

  // edge and mode helpers
  // decoded once, used by all branches
  logic rd_fall, rd_rise, wr_fall, wk_fall, afifo_on, bb_on;
  logic wstb, sstb;

  // receive buffer, engine to pins
  afb_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_rx_fifo (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .wr        (rx_in),
    .rd        (rx_out)
  );

  // transmit buffer, pins to engine
  afb_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_tx_fifo (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .wr        (tx_in),
    .rd        (tx_out)
  );

  // bit-bang flags stretched by a counter
  // a host pulse of one cycle would be
  // too short for slow far-side logic
  // width fixed by the strobe time constant
  // a new request restarts the count
  // flags are idle high outside bit-bang
  // bit-bang write flag width
  afb_strobe_gen #(.WIDTH(STB_CYC_W)) u_wstb (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_fire    (bb_on && i_bb_out_wr),
    .o_pulse   (wstb)
  );

  // bit-bang sample flag width
  afb_strobe_gen #(.WIDTH(STB_CYC_W)) u_sstb (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_fire    (bb_on && i_bb_sample),
    .o_pulse   (sstb)
  );

  // engine ready only in fifo mode
  // transmit side drains in every mode
  // so bytes written earlier still leave
  // engine stream hookup
  assign rx_in.data   = i_rx_data;
  assign rx_in.valid  = i_rx_valid && afifo_on;
  assign o_rx_ready   = rx_in.ready && afifo_on;
  assign o_tx_data    = tx_out.data;
  assign o_tx_valid   = tx_out.valid;
  assign tx_out.ready = i_tx_ready;

  // mode decode, levels not edges
  // host command overrides configuration
  // only the async code opens the fifo path
  // other codes leave the port idle, no interface clock
  // mode decode
  assign bb_on    = i_bb_cmd;
  assign afifo_on = !i_bb_cmd && (i_cfg_mode == MODE_AFIFO);

  // edge detect against the last sample
  // previous levels reset to idle high
  // so reset release gives no false edge
  // strobes are taken as synchronous
  // an async host needs its own synchroniser
  // strobe edges
  assign rd_fall = s_q.rd_n && !i_rd_n;
  assign rd_rise = !s_q.rd_n && i_rd_n;
  assign wr_fall = s_q.wr_n && !i_wr_n;
  assign wk_fall = s_q.wk_n && !i_send_now_wakeup_n;

  // write handshake
  // byte taken on the high-to-low edge
  // only while the space flag shows room
  // space flag lags the buffer by a cycle
  // a write in that cycle is dropped
  // a long low level captures only once
  // pop only for a read that was taken
  // a stray rise in idle pops nothing
  // fifo hooks: advance on read rise, capture on write fall
  assign rx_out.ready = afifo_on && rd_rise && (s_q.st == AFB_RD);
  assign tx_in.data   = i_port_data_lines;
  assign tx_in.valid  = afifo_on && wr_fall && !s_q.txs_n;

  // next state, one pass per clock
  // pulses and flags default to idle
  // status enables driven once out of reset
  // wakeup edge checked in every mode
  // suspend with wakeup: resume request
  // suspend without wakeup: ignored
  // normal operation: flush request
  // bit-bang wins over the fifo mode
  // a mode change in mid-read drops the bus
  // without popping the buffer
  // next-state logic
  always_comb
  begin
    s_d        = s_q;
    s_d.rd_n   = i_rd_n;
    s_d.wr_n   = i_wr_n;
    s_d.wk_n   = i_send_now_wakeup_n;
    s_d.resume = 1'b0;
    s_d.flush  = 1'b0;
    s_d.bb_v   = 1'b0;
    s_d.rxa_oe = 1'b1;
    s_d.txs_oe = 1'b1;
    // wakeup input serves every mode
    if (wk_fall)
    begin
      if (i_power_enable_n && i_remote_wake_en)
        s_d.resume = 1'b1;
      else if (!i_power_enable_n)
        s_d.flush = 1'b1;
    end
    // transmit space shown while a byte fits
    s_d.txs_n = !(afifo_on && tx_in.ready);
    // one state at a time, one-hot codes
    unique case (s_q.st)
      // idle: flag tracks the buffer
      // a taken read moves to the bus state
      AFB_IDLE:
      begin
        s_d.doe   = 8'h00;
        // receive-available follows buffer contents
        s_d.rxa_n = !(afifo_on && rx_out.valid);
        if (bb_on)
          s_d.st = AFB_BB;
        else if (afifo_on && rd_fall && !s_q.rxa_n)
        begin
          s_d.dout    = rx_out.data;
          s_d.doe     = 8'hFF;
          s_d.st      = AFB_RD;
        end
        else if (afifo_on && !i_wr_n)
          s_d.st = AFB_WR;
      end
      AFB_RD:
      begin
        // bus held until strobe returns high
        if (rd_rise || !afifo_on)
        begin
          s_d.doe   = 8'h00;
          s_d.rxa_n = 1'b1;
          s_d.st    = AFB_IDLE;
        end
      end
      AFB_WR:
      begin
        // capture happens on the fall, idle once the strobe is high
        if (wr_fall || !afifo_on || i_wr_n)
          s_d.st = AFB_IDLE;
      end
      AFB_BB:
      begin
        // pins follow the host direction mask
        s_d.dout  = i_bb_out_data;
        s_d.doe   = i_bb_out_dir;
        s_d.rxa_n = 1'b1;
        // sample taken from the resolved pins
        // valid lasts one cycle
        if (i_bb_sample)
        begin
          s_d.bb_in = i_port_data_lines;
          s_d.bb_v  = 1'b1;
        end
        if (!bb_on)
        begin
          s_d.doe = 8'h00;
          s_d.st  = AFB_IDLE;
        end
      end
    endcase
    // flags follow the stretched strobes
    // and the raw request on its first cycle
    s_d.wflag_n = !(bb_on && (wstb || i_bb_out_wr));
    s_d.sflag_n = !(bb_on && (sstb || i_bb_sample));
  end

  // reset: everything idle and released
  // status enables low, pull-ups take over
  // data enables low, host owns the lines
  // strobe history high to match idle pins
  // only constants in the reset branch
  // state register, status pins released in reset
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      s_q         <= '0;
      s_q.st      <= AFB_IDLE;
      s_q.rd_n    <= 1'b1;
      s_q.wr_n    <= 1'b1;
      s_q.wk_n    <= 1'b1;
      s_q.rxa_n   <= 1'b1;
      s_q.txs_n   <= 1'b1;
      s_q.rxa_oe  <= 1'b0;
      s_q.txs_oe  <= 1'b0;
      s_q.dout    <= DATA_RST;
      s_q.wflag_n <= 1'b1;
      s_q.sflag_n <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // pin outputs come from the state flops
  // engine streams come from the buffers
  // drive value may change while disabled
  // only the enable decides pin ownership
  // per-bit enables serve bit-bang direction
  // outputs straight from flops
  assign o_port_data_lines   = s_q.dout;
  assign o_port_data_oe      = s_q.doe;
  assign o_rx_available_n    = s_q.rxa_n;
  assign o_rx_available_oe   = s_q.rxa_oe;
  assign o_tx_space_n        = s_q.txs_n;
  assign o_tx_space_oe       = s_q.txs_oe;
  assign o_pin_write_flag_n  = s_q.wflag_n;
  assign o_pin_sample_flag_n = s_q.sflag_n;
  assign o_bb_in_data        = s_q.bb_in;
  assign o_bb_in_valid       = s_q.bb_v;
  assign o_resume_req        = s_q.resume;
  assign o_flush_req         = s_q.flush;
endmodule
`default_nettype wire

// *** afb_port_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// protocol checks on the port pins
module afb_port_props
  import afb_pkg::*;
(
  input wire logic       i_sys_clk,
  input wire logic       i_nrst,
  input wire logic [1:0] i_cfg_mode,
  input wire logic       i_bb_cmd,
  input wire logic       i_remote_wake_en,
  input wire logic       i_power_enable_n,
  input wire logic       i_rd_n,
  input wire logic       i_send_now_wakeup_n,
  input wire logic [7:0] i_bb_out_dir,
  input wire logic       i_bb_out_wr,
  input wire logic       i_bb_sample,
  input wire logic [7:0] o_port_data_oe,
  input wire logic       o_rx_available_n,
  input wire logic       o_rx_available_oe,
  input wire logic       o_tx_space_oe,
  input wire logic       o_pin_write_flag_n,
  input wire logic       o_pin_sample_flag_n,
  input wire logic       o_bb_in_valid,
  input wire logic       o_resume_req,
  input wire logic       o_flush_req
);
  logic af;  // fifo mode in force
  assign af = i_cfg_mode == MODE_AFIFO && !i_bb_cmd;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  // data lines and status pins
  a_oe_read_only: assert property (af && o_port_data_oe != 8'h00 |-> !$past(i_rd_n) || !$past(i_rd_n, 2))
    else $error("data lines driven without read strobe");
  a_status_released: assert property (disable iff (1'b0) !i_nrst |-> !o_rx_available_oe && !o_tx_space_oe)
    else $error("status pin driven in reset");
  a_read_present: assert property (af && $fell(i_rd_n) && !o_rx_available_n && o_port_data_oe == 8'h00
    |-> ##[1:2] o_port_data_oe == 8'hFF) else $error("read fall did not drive data");
  a_read_refused: assert property (af && $fell(i_rd_n) && o_rx_available_n |=> o_port_data_oe == 8'h00 [*2])
    else $error("read taken while nothing available");
  a_rise_flag_high: assert property (af && $rose(i_rd_n) && o_port_data_oe == 8'hFF
    |-> ##[1:2] (o_rx_available_n && o_port_data_oe == 8'h00)) else $error("read rise kept flag low");
  // wakeup strobe
  a_wake_resume: assert property ($fell(i_send_now_wakeup_n) && i_power_enable_n && i_remote_wake_en
    |=> o_resume_req) else $error("no resume request");
  a_flush_once: assert property ($fell(i_send_now_wakeup_n) && !i_power_enable_n
    |=> o_flush_req ##1 !o_flush_req) else $error("flush request not one pulse");
  // bit-bang strobes
  a_bb_write_flag: assert property (i_bb_cmd && i_bb_out_wr
    |=> !o_pin_write_flag_n && o_port_data_oe == $past(i_bb_out_dir)) else $error("write flag or direction wrong");
  a_bb_sample_edge: assert property (i_bb_cmd && i_bb_sample
    |=> o_bb_in_valid && !o_pin_sample_flag_n ##[1:5] o_pin_sample_flag_n) else $error("sample flag no rise");
  c_read: cover property (af && $fell(i_rd_n) && !o_rx_available_n);
  c_resume: cover property (o_resume_req);
  c_sample: cover property (o_bb_in_valid);
endmodule
bind afb_port afb_port_props i_props (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_cfg_mode(i_cfg_mode),
  .i_bb_cmd(i_bb_cmd), .i_remote_wake_en(i_remote_wake_en), .i_power_enable_n(i_power_enable_n),
  .i_rd_n(i_rd_n), .i_send_now_wakeup_n(i_send_now_wakeup_n), .i_bb_out_dir(i_bb_out_dir),
  .i_bb_out_wr(i_bb_out_wr), .i_bb_sample(i_bb_sample), .o_port_data_oe(o_port_data_oe),
  .o_rx_available_n(o_rx_available_n), .o_rx_available_oe(o_rx_available_oe), .o_tx_space_oe(o_tx_space_oe),
  .o_pin_write_flag_n(o_pin_write_flag_n), .o_pin_sample_flag_n(o_pin_sample_flag_n),
  .o_bb_in_valid(o_bb_in_valid), .o_resume_req(o_resume_req), .o_flush_req(o_flush_req));
`default_nettype wire

// *** afb_ext_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// external controller: async strobes, own pin drive
module afb_ext_host (
  input  wire logic       i_sys_clk,
  input  wire logic [7:0] i_dut_data,  // device drive value
  input  wire logic [7:0] i_dut_oe,    // device drive enable
  input  wire logic       i_rxa_n,     // receive flag pin level
  input  wire logic       i_txs_n,     // transmit flag pin level
  output logic            o_rd_n,      // read strobe
  output logic            o_wr_n,      // write strobe
  output logic      [7:0] o_pins       // resolved line level
);
  logic [7:0] drv_oe = 8'h00;  // own drive enable
  logic [7:0] drv_d  = 8'h00;  // own drive value
  logic [7:0] last_q = 8'h00;  // last line level
  logic       rise_flag = 1'b0;  // receive flag one cycle after the read rise
  initial o_rd_n = 1'b1;
  initial o_wr_n = 1'b1;
  // undriven bits show the inverse of their last level
  assign o_pins = (i_dut_oe & i_dut_data) | (~i_dut_oe & drv_oe & drv_d) | (~i_dut_oe & ~drv_oe & ~last_q);
  always @(posedge i_sys_clk) last_q <= o_pins;
  // set own pin drive
  task automatic set_drv(input logic [7:0] oe, input logic [7:0] d);
    drv_oe = oe;
    drv_d = d;
  endtask
  // one read pulse; any = ignore the flag
  task automatic rd(input bit any, output logic [7:0] d, output bit ok);
    @(negedge i_sys_clk);
    drv_oe = 8'h00;
    for (int n = 0; n < 100 && i_rxa_n !== 1'b0 && !any; n++) @(negedge i_sys_clk);
    ok = any || i_rxa_n === 1'b0;
    @(negedge i_sys_clk);
    o_rd_n = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    d = o_pins;
    o_rd_n = 1'b1;
    @(negedge i_sys_clk);
    rise_flag = i_rxa_n;
    @(negedge i_sys_clk);
  endtask
  // one write pulse, low then high; any = ignore the flag
  task automatic wr(input bit any, input logic [7:0] b, output bit ok);
    @(negedge i_sys_clk);
    drv_oe = 8'hFF;
    drv_d = b;
    for (int n = 0; n < 100 && i_txs_n !== 1'b0 && !any; n++) @(negedge i_sys_clk);
    ok = any || i_txs_n === 1'b0;
    repeat (2) @(negedge i_sys_clk);
    o_wr_n = 1'b0;
    repeat (3) @(negedge i_sys_clk);
    o_wr_n = 1'b1;
    @(negedge i_sys_clk);
    drv_oe = 8'h00;
  endtask
endmodule
`default_nettype wire

// *** async_fifo_bitbang_port_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module async_fifo_bitbang_port_test
  import afb_pkg::*;
;
  logic       clk = 1'b0, nrst = 1'b0, bb = 1'b0, wen = 1'b0, pwr_n = 1'b0, swu_n = 1'b1;
  logic       rx_v = 1'b0, tx_r = 1'b0, bo_wr = 1'b0, bs = 1'b0, oe_seen = 1'b0;
  logic [1:0] cfg = MODE_AFIFO;
  logic [7:0] rx_d = 8'h00, bo_d = 8'h00, bo_dir = 8'h00;
  logic [7:0] pins, pd, poe, tx_d, bi_d;
  logic       rd_n, wr_n, rxa_n, rxa_oe, txs_n, txs_oe, wf_n, sf_n, rx_rdy, tx_v, bi_v, res, fl;
  logic       rxa_p, txs_p;  // status pins, pulled up while released
  int         errors = 0;
  int         num_checks = 0;
  assign rxa_p = rxa_oe ? rxa_n : 1'b1;
  assign txs_p = txs_oe ? txs_n : 1'b1;
  always #25 clk = ~clk;
  // note any drive of the data lines
  always @(posedge clk) if (poe !== 8'h00) oe_seen = 1'b1;
  afb_port i_dut (.i_sys_clk(clk), .i_nrst(nrst), .i_cfg_mode(cfg), .i_bb_cmd(bb), .i_remote_wake_en(wen),
    .i_power_enable_n(pwr_n), .i_port_data_lines(pins), .o_port_data_lines(pd), .o_port_data_oe(poe),
    .i_rd_n(rd_n), .i_wr_n(wr_n), .i_send_now_wakeup_n(swu_n), .o_rx_available_n(rxa_n),
    .o_rx_available_oe(rxa_oe), .o_tx_space_n(txs_n), .o_tx_space_oe(txs_oe), .o_pin_write_flag_n(wf_n),
    .o_pin_sample_flag_n(sf_n), .i_rx_data(rx_d), .i_rx_valid(rx_v), .o_rx_ready(rx_rdy), .o_tx_data(tx_d),
    .o_tx_valid(tx_v), .i_tx_ready(tx_r), .i_bb_out_data(bo_d), .i_bb_out_dir(bo_dir), .i_bb_out_wr(bo_wr),
    .i_bb_sample(bs), .o_bb_in_data(bi_d), .o_bb_in_valid(bi_v), .o_resume_req(res), .o_flush_req(fl));
  afb_ext_host u_host (.i_sys_clk(clk), .i_dut_data(pd), .i_dut_oe(poe), .i_rxa_n(rxa_p), .i_txs_n(txs_p),
    .o_rd_n(rd_n), .o_wr_n(wr_n), .o_pins(pins));
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // engine hands one byte to the receive buffer
  task automatic push(input logic [7:0] b);
    int n;
    rx_d = b;
    rx_v = 1'b1;
    for (n = 0; n < 50 && rx_rdy !== 1'b1; n++) @(negedge clk);
    if (n == 50)
    begin
      check("rx ready wait", 8'h00, 8'h01);
      test_done();
    end
    @(negedge clk);
  endtask
  // fill receive buffer, read it all back, then read while empty
  task automatic t_rx;
    logic [7:0] d;
    bit         ok;
    for (int i = 0; i < 32; i++) push(8'h40 + 8'(i));
    rx_v = 1'b0;
    check("rx full", {7'h0, rx_rdy}, 8'h00);
    for (int i = 0; i < 32; i++)
    begin
      u_host.rd(1'b0, d, ok);
      check("rx wait", {7'h0, ok}, 8'h01);
      check("rx byte", d, 8'h40 + 8'(i));
      check("rx flag high", {7'h0, u_host.rise_flag}, 8'h01);
    end
    repeat (3) @(negedge clk);
    check("rx empty flag", {7'h0, rxa_p}, 8'h01);
    oe_seen = 1'b0;
    u_host.rd(1'b1, d, ok);
    check("empty read drive", {7'h0, oe_seen}, 8'h00);
  endtask
  // read strobe outside fifo mode is ignored and pops nothing
  task automatic t_mode;
    logic [7:0] d;
    bit         ok;
    push(8'h77);
    rx_v = 1'b0;
    cfg = MODE_OFF;
    oe_seen = 1'b0;
    u_host.rd(1'b1, d, ok);
    check("off mode drive", {7'h0, oe_seen}, 8'h00);
    cfg = MODE_AFIFO;
    u_host.rd(1'b0, d, ok);
    check("kept byte", d, 8'h77);
  endtask
  // fill transmit buffer with engine stalled, one refused write, drain
  task automatic t_tx;
    int k;
    bit ok;
    for (int i = 0; i < 32; i++)
    begin
      u_host.wr(1'b0, 8'hC0 + 8'(i), ok);
      check("tx wait", {7'h0, ok}, 8'h01);
    end
    check("tx full", {7'h0, txs_p}, 8'h01);
    u_host.wr(1'b1, 8'hEE, ok);
    tx_r = 1'b1;
    k = 0;
    repeat (40)
    begin
      if (tx_v === 1'b1)
      begin
        check("tx byte", tx_d, 8'hC0 + 8'(k));
        k++;
      end
      @(negedge clk);
    end
    check("tx count", 8'(k), 8'h20);
    check("tx space", {7'h0, txs_p}, 8'h00);
  endtask
  // wakeup strobe: suspended with wakeup, suspended without, normal
  task automatic t_wake;
    for (int c = 0; c < 3; c++)
    begin
      logic r;
      logic f;
      r = 1'b0;
      f = 1'b0;
      pwr_n = c < 2;
      wen = c == 0;
      swu_n = 1'b0;
      repeat (3)
      begin
        @(negedge clk);
        r = r | res;
        f = f | fl;
      end
      swu_n = 1'b1;
      check("resume", {7'h0, r}, {7'h0, c == 0});
      check("flush", {7'h0, f}, {7'h0, c == 2});
      repeat (2) @(negedge clk);
    end
  endtask
  // bit-bang: split drive of the lines, write flag, sample flag
  task automatic t_bb;
    int n;
    bb = 1'b1;
    u_host.set_drv(8'h0F, 8'h3C);
    repeat (2) @(negedge clk);
    bo_d = 8'hA5;
    bo_dir = 8'hF0;
    bo_wr = 1'b1;
    @(negedge clk);
    bo_wr = 1'b0;
    check("write flag", {7'h0, wf_n}, 8'h00);
    check("pin dir", poe, 8'hF0);
    @(negedge clk);
    check("pin level", pins, 8'hAC);
    bs = 1'b1;
    @(negedge clk);
    bs = 1'b0;
    check("sample valid", {7'h0, bi_v}, 8'h01);
    check("sample data", bi_d, 8'hAC);
    check("sample flag low", {7'h0, sf_n}, 8'h00);
    for (n = 0; n < 8 && sf_n !== 1'b1; n++) @(negedge clk);
    check("sample flag rise", {7'h0, sf_n}, 8'h01);
  endtask
  // reset, then the scenarios; bit-bang last
  initial
  begin
    repeat (4) @(negedge clk);
    check("rx oe reset", {7'h0, rxa_oe}, 8'h00);
    check("tx oe reset", {7'h0, txs_oe}, 8'h00);
    check("flags reset", {6'h0, wf_n, sf_n}, 8'h03);
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    t_rx();
    t_mode();
    t_tx();
    t_wake();
    t_bb();
    test_done();
  end
endmodule
`default_nettype wire
